// >>> hdl/cpu_reset_state_init.sv
// Purpose: Accepts the external reset and sets the CPU and peripheral initial state.
// Assumes: Reset pin, straps and NMI pin are synchronous to clk_i.
// Notes: Vector bytes arrive on a fetch port; PC and state leave on outputs.
`timescale 1ns/1ps
`include "cpu_reset_map.svh"
module cpu_reset_state_init (
    // Clock and block reset
    input  wire logic                               clk_i,
    input  wire logic                               sys_rst_i,
    // External reset pin, straps and NMI
    input  wire logic                               reset_pin_n_i,
    input  wire logic                               bus_mode_strap_low_i,
    input  wire logic                               bus_mode_strap_high_i,
    input  wire logic                               nmi_n_i,
    // Vector fetch port
    input  wire logic [7:0]                         vec_data_i,
    input  wire logic                               vec_valid_i,
    output logic      [23:0]                        vec_addr_o,
    output logic                                    vec_req_o,
    // Access routing
    input  wire logic [23:0]                        acc_addr_i,
    output logic                                    acc_external_o,
    // Register port
    input  wire logic [3:0]                         reg_addr_i,
    input  wire logic [31:0]                        reg_wdata_i,
    input  wire logic                               reg_we_i,
    input  wire logic                               reg_re_i,
    output logic      [31:0]                        reg_rdata_o,
    // CPU state
    output logic      [23:0]                        pc_o,
    output logic      [31:0]                        system_stack_pointer_o,
    output cpu_reset_pkg::cpu_status_word_t         cpu_status_word_o,
    output logic                                    cpu_run_o,
    output logic                                    cpu_in_reset_o,
    // Clock control and peripheral state
    output logic                                    doubler_on_o,
    output logic      [2:0]                         gear_o,
    output logic      [7:0]                         port_alt_mode_o,
    output cpu_reset_pkg::bus_mode_t                bus_mode_o,
    output logic                                    nmi_event_o
);

    // ************************************************************
    // Reset acceptance
    // ************************************************************
    typedef enum logic [2:0] {
        S_RUN,
        S_HOLD,
        S_FETCH_LO,
        S_FETCH_MID,
        S_FETCH_HI,
        S_WAIT_RELEASE
    } seq_state_t;

    seq_state_t  state_q;
    logic [3:0]  low_cnt_q;
    logic        accepted;
    logic [1:0]  byte_sel;
    cpu_reset_pkg::reg_req_t req;

    function automatic logic in_lcd_range(input logic [23:0] a);
        in_lcd_range = (a >= `EXT_LCD_LO) && (a <= `EXT_LCD_HI);
    endfunction : in_lcd_range

    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, we: reg_we_i, re: reg_re_i};

    // Short glitches on the pin never restart the CPU: only a full run counts.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            low_cnt_q <= 4'h0;
        end else if (reset_pin_n_i) begin
            low_cnt_q <= 4'h0;
        end else if (low_cnt_q != `RST_MIN_STATES) begin
            low_cnt_q <= low_cnt_q + 4'h1; // [R16]
        end
    end

    // The tenth consecutive low sample accepts, so a source that keeps the minimum is never refused.
    assign accepted = !reset_pin_n_i && (low_cnt_q >= (`RST_MIN_STATES - 4'h1)); // [R1] [R16]

    // ************************************************************
    // Sequencer: hold, fetch the vector, start
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= S_HOLD;
        end else begin
            unique case (state_q)
                S_RUN: begin
                    if (accepted) begin
                        state_q <= S_FETCH_LO;
                    end
                end
                S_HOLD: begin
                    if (accepted) begin
                        state_q <= S_FETCH_LO;
                    end
                end
                S_FETCH_LO: begin
                    if (vec_valid_i) begin
                        state_q <= S_FETCH_MID;
                    end
                end
                S_FETCH_MID: begin
                    if (vec_valid_i) begin
                        state_q <= S_FETCH_HI;
                    end
                end
                S_FETCH_HI: begin
                    if (vec_valid_i) begin
                        state_q <= S_WAIT_RELEASE;
                    end
                end
                S_WAIT_RELEASE: begin
                    if (reset_pin_n_i) begin
                        state_q <= S_RUN; // [R9]
                    end
                end
                default: begin
                    state_q <= S_HOLD;
                end
            endcase
        end
    end

    always_comb begin
        unique case (state_q)
            S_FETCH_MID: byte_sel = 2'h1;
            S_FETCH_HI:  byte_sel = 2'h2;
            default:     byte_sel = 2'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            vec_addr_o <= `VEC_ADDR_LO;
            vec_req_o  <= 1'b0;
        end else begin
            vec_req_o <= (state_q == S_FETCH_LO || state_q == S_FETCH_MID || state_q == S_FETCH_HI)
                         && !vec_valid_i;
            unique case (byte_sel)
                2'h1:    vec_addr_o <= `VEC_ADDR_MID; // [R3]
                2'h2:    vec_addr_o <= `VEC_ADDR_HI;  // [R3]
                default: vec_addr_o <= `VEC_ADDR_LO;  // [R3]
            endcase
        end
    end

    // ************************************************************
    // CPU state: only PC, status word and stack pointer are forced
    // ************************************************************
    // Program counter loads byte-wise, low byte first.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pc_o <= 24'h000000;
        end else if (vec_valid_i && state_q == S_FETCH_LO) begin
            pc_o[7:0] <= vec_data_i; // [R3]
        end else if (vec_valid_i && state_q == S_FETCH_MID) begin
            pc_o[15:8] <= vec_data_i; // [R3]
        end else if (vec_valid_i && state_q == S_FETCH_HI) begin
            pc_o[23:16] <= vec_data_i; // [R3]
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            system_stack_pointer_o <= `SP_RESET;
        end else if (accepted) begin
            system_stack_pointer_o <= `SP_RESET; // [R4]
        end else if (req.we && req.addr == `REG_SP) begin
            system_stack_pointer_o <= req.wdata;
        end
    end

    // The flag write from software is ignored; clearing it would select an unsupported mode.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cpu_status_word_o <= '{maximum_mode: 1'b1, interrupt_mask_level: `IMASK_RESET,
                                   register_bank_select: `BANK_RESET};
        end else if (accepted) begin
            cpu_status_word_o.interrupt_mask_level <= `IMASK_RESET; // [R5]
            cpu_status_word_o.maximum_mode         <= 1'b1;         // [R6]
            cpu_status_word_o.register_bank_select <= `BANK_RESET;  // [R8]
        end else if (req.we && req.addr == `REG_STATUS) begin
            cpu_status_word_o.interrupt_mask_level <= req.wdata[5:3];
            cpu_status_word_o.register_bank_select <= req.wdata[2:0];
            cpu_status_word_o.maximum_mode         <= 1'b1; // [R7]
        end
    end

    // No other CPU register or RAM is reset here; those stay with the core. [R10]
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cpu_run_o      <= 1'b0;
            cpu_in_reset_o <= 1'b1;
        end else begin
            cpu_run_o      <= (state_q == S_RUN) && !accepted; // [R9]
            cpu_in_reset_o <= (state_q != S_RUN) || accepted;
        end
    end

    // ************************************************************
    // Clock control, ports, peripheral registers
    // ************************************************************
    logic nmi_both_q;
    logic nmi_prev_q;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || accepted) begin
            doubler_on_o <= `DOUBLER_X1; // [R2]
            gear_o       <= `GEAR_DIV16; // [R2]
        end else if (req.we && req.addr == `REG_CLKCTL) begin
            doubler_on_o <= req.wdata[3];
            gear_o       <= req.wdata[2:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || accepted) begin
            port_alt_mode_o <= `PORTMODE_RESET; // [R12]
            nmi_both_q      <= 1'b0;            // [R11]
        end else if (req.we && req.addr == `REG_PORTMODE) begin
            port_alt_mode_o <= req.wdata[7:0];
        end else if (req.we && req.addr == `REG_NMICTL) begin
            nmi_both_q <= req.wdata[0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            nmi_prev_q  <= 1'b1;
            nmi_event_o <= 1'b0;
        end else begin
            nmi_prev_q  <= nmi_n_i;
            nmi_event_o <= (nmi_prev_q && !nmi_n_i) || (nmi_both_q && !nmi_prev_q && nmi_n_i); // [R15]
        end
    end

    // Straps are re-read every cycle; an unsupported code is reported, not remapped.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            bus_mode_o <= cpu_reset_pkg::BUS_8_FIXED;
        end else if (!bus_mode_strap_high_i && bus_mode_strap_low_i) begin
            bus_mode_o <= cpu_reset_pkg::BUS_16_DYNAMIC; // [R13]
        end else if (!bus_mode_strap_high_i && !bus_mode_strap_low_i) begin
            bus_mode_o <= cpu_reset_pkg::BUS_8_FIXED; // [R13]
        end else begin
            bus_mode_o <= cpu_reset_pkg::BUS_UNSUPPORTED;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            acc_external_o <= 1'b0;
        end else begin
            acc_external_o <= in_lcd_range(acc_addr_i); // [R14]
        end
    end

    // ************************************************************
    // Register read port
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (req.re) begin
            unique case (req.addr)
                `REG_CLKCTL:   reg_rdata_o <= {28'h0000000, doubler_on_o, gear_o};
                `REG_NMICTL:   reg_rdata_o <= {31'h0, nmi_both_q};
                `REG_PORTMODE: reg_rdata_o <= {24'h000000, port_alt_mode_o};
                `REG_STATUS:   reg_rdata_o <= {25'h0, cpu_status_word_o};
                `REG_PC:       reg_rdata_o <= {8'h00, pc_o};
                `REG_SP:       reg_rdata_o <= system_stack_pointer_o;
                default:       reg_rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

endmodule : cpu_reset_state_init

// >>> hdl/cpu_reset_map.svh
// Purpose: Constants for the reset acceptance and initial-state block.
// Assumes: One 125 MHz system clock; the block counts states in it.
// Notes: Offsets are register-port addresses of this block.
// Function
// [R1] Reset source holds reset low ten states.
// [R2] Reset forces doubler x1, gear divide-by-16.
// [R3] Program counter loads from three vector bytes.
// [R4] Stack pointer presets to 100H.
// [R5] Interrupt mask level presets to 111.
// [R6] Maximum-mode flag presets to one.
// [R7] Software never writes zero to maximum-mode.
// [R8] Register bank select clears to 000.
// [R9] Fetch starts at program counter after release.
// [R10] Other registers and RAM stay unchanged.
// [R11] Peripheral control registers return to initial values.
// [R12] Port pins revert to general-purpose mode.
// [R13] Bus width chosen from two mode straps.
// [R14] 000FE0H to 00FFFH routes to external memory.
// [R15] NMI triggers falling edge or both edges.
// [R16] Reset accepted after full consecutive low count.
`ifndef CPU_RESET_MAP_SVH
`define CPU_RESET_MAP_SVH
`define RST_MIN_STATES      4'ha
`define VEC_ADDR_LO         24'hffff00
`define VEC_ADDR_MID        24'hffff01
`define VEC_ADDR_HI         24'hffff02
`define SP_RESET            32'h0000_0100
`define IMASK_RESET         3'h7
`define BANK_RESET          3'h0
`define GEAR_DIV16          3'h4
`define DOUBLER_X1          1'h0
`define EXT_LCD_LO          24'h000fe0
`define EXT_LCD_HI          24'h000fff
`define REG_CLKCTL          4'h0
`define REG_NMICTL          4'h1
`define REG_PORTMODE        4'h2
`define REG_STATUS          4'h3
`define REG_PC              4'h4
`define REG_SP              4'h5
`define PORTMODE_RESET      8'h00
`endif

// >>> hdl/cpu_reset_pkg.sv
// Purpose: Types for the reset acceptance and initial-state block.
// Assumes: Used with cpu_reset_map.svh.
// Notes: Status word layout is packed for the status output.
package cpu_reset_pkg;
    typedef enum logic [1:0] {
        BUS_8_FIXED,
        BUS_16_DYNAMIC,
        BUS_UNSUPPORTED
    } bus_mode_t;

    typedef struct packed {
        logic       maximum_mode;
        logic [2:0] interrupt_mask_level;
        logic [2:0] register_bank_select;
    } cpu_status_word_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        we;
        logic        re;
    } reg_req_t;
endpackage : cpu_reset_pkg

// >>> verif/cpu_reset_state_init_properties.sv
// Purpose: Port-level timing checks for the reset acceptance block.
// Assumes: One clock domain; sys_rst_i is synchronous and active high.
// Notes: A local counter tracks consecutive low samples of the reset pin.
`timescale 1ns/1ps
module cpu_reset_state_init_properties (
    // Clock, reset, pins and handshakes
    input wire logic clk_i, sys_rst_i, reset_pin_n_i, nmi_n_i, vec_valid_i, vec_req_o, cpu_run_o,
    input wire logic bus_mode_strap_low_i, bus_mode_strap_high_i, acc_external_o, doubler_on_o, nmi_event_o,
    // Buses and state
    input wire logic [7:0]                 vec_data_i, port_alt_mode_o,
    input wire logic [2:0]                 gear_o,
    input wire logic [23:0]                vec_addr_o, acc_addr_i, pc_o,
    input wire logic [31:0]                system_stack_pointer_o,
    input wire cpu_reset_pkg::cpu_status_word_t cpu_status_word_o,
    input wire cpu_reset_pkg::bus_mode_t   bus_mode_o
);
    logic [4:0] low_cnt_q;
    wire        in_rng_w = (acc_addr_i >= 24'h000fe0) && (acc_addr_i <= 24'h000fff);
    // Saturates so a long hold never wraps back below the acceptance count.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || reset_pin_n_i) low_cnt_q <= 5'h00;
        else if (low_cnt_q != 5'h1f) low_cnt_q <= low_cnt_q + 5'h01;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_byte(logic [23:0] a);
        vec_req_o && vec_valid_i && vec_addr_o == a;
    endsequence
    a_reset_forces_core: assert property (low_cnt_q >= 5'h0a |-> system_stack_pointer_o == 32'h0000_0100
        && cpu_status_word_o == 7'h78) else $error("core state not forced on accepted reset");
    a_clock_slowest: assert property (low_cnt_q >= 5'h0a |-> gear_o == 3'h4 && !doubler_on_o)
        else $error("clock not forced to slowest setting");
    a_ports_general: assert property (low_cnt_q >= 5'h0a |-> port_alt_mode_o == 8'h00)
        else $error("port modes not reverted");
    a_short_refused: assert property ($fell(cpu_run_o) |-> low_cnt_q >= 5'h0a)
        else $error("run stopped by too short a reset");
    a_vec_lo_next: assert property (s_byte(24'hffff00) |-> ##[1:4] (vec_req_o && vec_addr_o == 24'hffff01))
        else $error("middle vector byte not fetched next");
    a_pc_low_byte: assert property (s_byte(24'hffff00) |=> pc_o[7:0] == $past(vec_data_i))
        else $error("low vector byte not loaded");
    a_pc_top_byte: assert property (s_byte(24'hffff02) |=> pc_o[23:16] == $past(vec_data_i))
        else $error("top vector byte not loaded");
    a_run_after_release: assert property ($rose(cpu_run_o) |-> reset_pin_n_i && $past(reset_pin_n_i))
        else $error("run began before reset release");
    a_pc_held_run: assert property (cpu_run_o && reset_pin_n_i |=> $stable(pc_o))
        else $error("program counter moved while running");
    a_route_ext: assert property (!sys_rst_i |=> acc_external_o == $past(in_rng_w))
        else $error("external routing wrong");
    a_bus_width: assert property (!bus_mode_strap_high_i |=>
        bus_mode_o == ($past(bus_mode_strap_low_i) ? cpu_reset_pkg::BUS_16_DYNAMIC : cpu_reset_pkg::BUS_8_FIXED))
        else $error("bus width does not follow straps");
    a_nmi_fall: assert property ($fell(nmi_n_i) |-> ##[1:2] nmi_event_o)
        else $error("no event on falling nmi");
    a_max_held: assert property (cpu_status_word_o.maximum_mode == 1'b1)
        else $error("maximum mode flag cleared");
endmodule : cpu_reset_state_init_properties

bind cpu_reset_state_init cpu_reset_state_init_properties u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reset_pin_n_i(reset_pin_n_i), .nmi_n_i(nmi_n_i), .vec_valid_i(vec_valid_i), .vec_req_o(vec_req_o),
    .cpu_run_o(cpu_run_o), .bus_mode_strap_low_i(bus_mode_strap_low_i), .bus_mode_strap_high_i(bus_mode_strap_high_i),
    .acc_external_o(acc_external_o), .doubler_on_o(doubler_on_o), .nmi_event_o(nmi_event_o),
    .vec_data_i(vec_data_i), .port_alt_mode_o(port_alt_mode_o), .gear_o(gear_o), .vec_addr_o(vec_addr_o),
    .acc_addr_i(acc_addr_i), .pc_o(pc_o), .system_stack_pointer_o(system_stack_pointer_o),
    .cpu_status_word_o(cpu_status_word_o), .bus_mode_o(bus_mode_o));

// >>> verif/vector_source_model.sv
// Purpose: Memory model that answers reset-vector byte fetches.
// Assumes: Requests hold address until the valid pulse is taken.
// Notes: While no request is pending the data lines toggle so stale bytes cannot pass; they hold during the latency wait.
`timescale 1ns/1ps
module vector_source_model (
    input  wire logic        clk_i,
    input  wire logic        req_i,
    input  wire logic [23:0] addr_i,
    input  wire logic [23:0] vector_i,
    input  wire logic [3:0]  lat_i,
    output logic      [7:0]  data_o,
    output logic             valid_o
);
    initial begin
        data_o  = 8'h00;
        valid_o = 1'b0;
    end
    always begin
        @(posedge clk_i);
        if (req_i) begin
            repeat (lat_i) @(posedge clk_i);
            data_o  <= (addr_i == 24'hffff00) ? vector_i[7:0] :
                       (addr_i == 24'hffff01) ? vector_i[15:8] : vector_i[23:16];
            valid_o <= 1'b1;
            @(posedge clk_i);
            valid_o <= 1'b0;
            data_o  <= ~data_o;
            @(posedge clk_i);
        end else begin
            data_o <= ~data_o;
        end
    end
endmodule : vector_source_model

// >>> verif/cpu_reset_state_init_tb.sv
// Purpose: Self-checking bench for the reset acceptance block.
// Assumes: Inputs change by non-blocking assignment at rising edges.
// Notes: Register reads are scored from a queue of expected values.
`timescale 1ns/1ps
`include "cpu_reset_map.svh"
module cpu_reset_state_init_tb;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, reset_pin_n_i = 1'b1, nmi_n_i = 1'b1, vec_valid_i, vec_req_o;
    logic bus_mode_strap_low_i = 1'b1, bus_mode_strap_high_i = 1'b0, reg_we_i = 1'b0, reg_re_i = 1'b0;
    logic acc_external_o, cpu_run_o, cpu_in_reset_o, doubler_on_o, nmi_event_o, rd_pend = 1'b0;
    logic [7:0] vec_data_i, port_alt_mode_o, pm;
    logic [3:0] reg_addr_i = 4'h0, lat = 4'h0, g;
    logic [2:0] gear_o;
    logic [23:0] vec_addr_o, pc_o, vec, acc_addr_i = 24'h000000;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, system_stack_pointer_o, sp;
    logic [31:0] exp_q[$];
    cpu_reset_pkg::cpu_status_word_t cpu_status_word_o;
    cpu_reset_pkg::bus_mode_t bus_mode_o;
    int mismatches = 0, cmp_count = 0, cycles = 0, nmi_cnt = 0;
    initial forever #4 clk_i = ~clk_i;
    cpu_reset_state_init u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reset_pin_n_i(reset_pin_n_i),
        .bus_mode_strap_low_i(bus_mode_strap_low_i), .bus_mode_strap_high_i(bus_mode_strap_high_i),
        .nmi_n_i(nmi_n_i), .vec_data_i(vec_data_i), .vec_valid_i(vec_valid_i), .vec_addr_o(vec_addr_o),
        .vec_req_o(vec_req_o), .acc_addr_i(acc_addr_i), .acc_external_o(acc_external_o), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
        .pc_o(pc_o), .system_stack_pointer_o(system_stack_pointer_o), .cpu_status_word_o(cpu_status_word_o),
        .cpu_run_o(cpu_run_o), .cpu_in_reset_o(cpu_in_reset_o), .doubler_on_o(doubler_on_o), .gear_o(gear_o),
        .port_alt_mode_o(port_alt_mode_o), .bus_mode_o(bus_mode_o), .nmi_event_o(nmi_event_o));
    vector_source_model u_vec (.clk_i(clk_i), .req_i(vec_req_o), .addr_i(vec_addr_o), .vector_i(vec),
        .lat_i(lat), .data_o(vec_data_i), .valid_o(vec_valid_i));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a; reg_wdata_i <= d; reg_we_i <= 1'b1;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_i);
        reg_addr_i <= a; reg_re_i <= 1'b1; exp_q.push_back(e);
        @(posedge clk_i);
        reg_re_i <= 1'b0;
    endtask : rd
    // The reset source holds the pin low for exactly n sampled states.
    task automatic pin_low(input int n);
        @(posedge clk_i);
        reset_pin_n_i <= 1'b0;
        repeat (n) @(posedge clk_i);
        reset_pin_n_i <= 1'b1;
    endtask : pin_low
    task automatic full_reset(input logic [3:0] l, input int n);
        vec = 24'($urandom); lat <= l;
        pin_low(n);
        // The run flag drops at the accepting edge; wait one edge so a stale high is not taken as the restart.
        @(posedge clk_i);
        for (int i = 0; i < 300 && cpu_run_o !== 1'b1; i++) @(posedge clk_i);
        #1 check(cpu_run_o, 1'b1);
        check(cpu_in_reset_o, 1'b0);
        check(pc_o, vec);
        check(system_stack_pointer_o, 32'h0000_0100);
        check(cpu_status_word_o, 7'h78);
        check({doubler_on_o, gear_o}, 4'h4);
        check(port_alt_mode_o, 8'h00);
        rd(`REG_CLKCTL, 32'h4); rd(`REG_PORTMODE, 32'h0);
        rd(`REG_NMICTL, 32'h0); rd(`REG_PC, {8'h0, vec});
    endtask : full_reset
    always @(posedge clk_i) begin
        if (rd_pend) check(reg_rdata_o, exp_q.pop_front());
        rd_pend <= reg_re_i;
        if (nmi_event_o === 1'b1) nmi_cnt++;
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end
    initial begin
        void'($urandom(54961));
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        #1 check(cpu_run_o, 1'b0);
        check(cpu_status_word_o, 7'h78);
        full_reset(4'h0, 11);
        g = 4'($urandom); pm = 8'($urandom); sp = $urandom;
        wr(`REG_CLKCTL, {28'h0, g}); wr(`REG_PORTMODE, {24'h0, pm}); wr(`REG_SP, sp);
        wr(`REG_STATUS, 32'h4a);
        wr(`REG_PC, $urandom); wr(4'h6 + 4'($urandom % 10), $urandom);
        rd(`REG_CLKCTL, {28'h0, g}); rd(`REG_SP, sp); rd(`REG_PC, {8'h0, vec}); rd(4'hf, 32'h0);
        pin_low(9); pin_low(9);
        repeat (3) @(posedge clk_i);
        #1 check(cpu_run_o, 1'b1);
        check({doubler_on_o, gear_o}, g); check(port_alt_mode_o, pm);
        check(cpu_status_word_o, 7'h4a);
        full_reset(4'h5, 10);
        foreach (vec[i]) begin
            @(posedge clk_i);
            acc_addr_i <= (i < 4) ? 24'h000fdf + 24'(i == 1) + 24'(i > 1) * 24'h20 : 24'($urandom % 24'h1400);
            @(posedge clk_i);
            #1 check(acc_external_o, (acc_addr_i >= 24'h000fe0) && (acc_addr_i <= 24'h000fff));
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            {bus_mode_strap_high_i, bus_mode_strap_low_i} <= 2'(i);
            repeat (3) @(posedge clk_i);
            #1 check(bus_mode_o, i == 1 ? cpu_reset_pkg::BUS_16_DYNAMIC :
                (i == 0 ? cpu_reset_pkg::BUS_8_FIXED : cpu_reset_pkg::BUS_UNSUPPORTED));
        end
        for (int m = 0; m < 2; m++) begin
            wr(`REG_NMICTL, 32'(m)); rd(`REG_NMICTL, 32'(m));
            @(posedge clk_i); nmi_n_i <= 1'b0;
            repeat (5) @(posedge clk_i); nmi_n_i <= 1'b1;
            repeat (5) @(posedge clk_i);
            #1 check(nmi_cnt, m == 0 ? 1 : 3);
        end
        repeat (3) @(posedge clk_i);
        conclude();
    end
endmodule : cpu_reset_state_init_tb
